// file: pkg/rcp_pkg.sv
// Purpose: shared constants and types for the channel config command link
// Assumes: 250 MHz core clock, 2400 baud text link on select pin 0
// Notes: word codes are ascii, right aligned, zero filled above
package rcp_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_HZ = 250_000_000;
    localparam int BAUD = 2400;
    localparam int BIT_CYC = CLK_HZ / BAUD;
    localparam int GAP_MS = 50;
    localparam int GAP_CYC = CLK_HZ / 1000 * GAP_MS;
    localparam int STABLE_MS = 50;
    localparam int STABLE_CYC = CLK_HZ / 1000 * STABLE_MS;
    // ****************************************
    // limits and field positions
    // ****************************************
    localparam int NCHAN = 32;
    localparam int CHAN_MAX = 31;
    localparam int N_MAX = 65535;
    localparam int CHAN_DIGITS = 2;
    localparam int R_W = 14;
    localparam int R_RSV_BIT = 14;
    localparam int R_OFS_BIT = 15;
    localparam logic [16:0] N_OFS = 17'h10000;
    localparam logic [15:0] DEF_N = 16'h8098;
    localparam logic [15:0] DEF_R = 16'h0208;
    // ****************************************
    // characters and command words
    // ****************************************
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] CH_SP = 8'h20;
    localparam logic [7:0] CH_HASH = 8'h23;
    localparam logic [7:0] CH_CLR = 8'h31;
    localparam logic [7:0] CH_0 = 8'h30;
    localparam logic [7:0] CH_9 = 8'h39;
    localparam logic [127:0] W_UNLOCK = 128'h454e41424c4553455249414c4d4f4445;
    localparam logic [127:0] W_GOCHAN = 128'h474f4348414e;
    localparam logic [127:0] W_LOAD = 128'h4c4f4144;
    localparam logic [127:0] W_PAR = 128'h534554504152;
    localparam logic [127:0] W_SER = 128'h534554534552;
    localparam logic [127:0] W_RDIV = 128'h5256414c5545;
    localparam logic [127:0] W_SINGLE = 128'h53494e474c45;
    typedef enum logic [1:0] {RCP_PAR, RCP_SER, RCP_SINGLE} rcp_mode_type;
    // ****************************************
    // host register map
    // ****************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_SEL = 8'h04;
    localparam logic [7:0] REG_TX = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0c;
    localparam int CTRL_PGM = 0;
    localparam int CTRL_STOP2 = 1;
    localparam logic [3:0] FRM_BITS1 = 4'ha;
    localparam logic [3:0] FRM_BITS2 = 4'hb;
endpackage

// file: pkg/rcp_link_if.sv
// Purpose: select pins between host and receiver
// Assumes: host drives all four pins, receiver only reads them
// Notes: pins are active low; pin 0 doubles as the text line
`timescale 1ns/1ps
interface rcp_link_if;
    logic [3:0] sel_n;
    modport host (output sel_n);
    modport dev (input sel_n);
endinterface

// file: core/rcp_uart_rx.sv
// Purpose: byte receiver for the command text line
// Assumes: rx_i already synchronised, idle high, lsb first
// Notes: a bad stop bit drops the byte silently
`timescale 1ns/1ps
module rcp_uart_rx #(
    parameter int BIT_CYC = rcp_pkg::BIT_CYC
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // line and byte out
    input wire logic rx_i,
    output logic [7:0] data_o,
    output logic valid_o
);
    localparam int CW = $clog2(BIT_CYC + 1);
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rcp_rx_type;
    rcp_rx_type st_r;
    logic [CW-1:0] cnt_r;
    logic [2:0] nb_r;
    wire half_w = (cnt_r == CW'(BIT_CYC / 2 - 1));
    wire full_w = (cnt_r == CW'(BIT_CYC - 1));

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= RX_IDLE;
            cnt_r <= '0;
            nb_r <= '0;
            data_o <= '0;
            valid_o <= 1'b0;
        end else begin
            valid_o <= 1'b0;
            cnt_r <= cnt_r + CW'(1);
            case (st_r)
                RX_IDLE: begin
                    cnt_r <= '0;
                    if (!rx_i) st_r <= RX_START;
                end
                RX_START: if (half_w) begin
                    // recheck mid start bit so a glitch is not taken as a byte
                    cnt_r <= '0;
                    nb_r <= '0;
                    st_r <= rx_i ? RX_IDLE : RX_DATA;
                end
                RX_DATA: if (full_w) begin
                    cnt_r <= '0;
                    data_o <= {rx_i, data_o[7:1]};
                    nb_r <= nb_r + 3'h1;
                    if (nb_r == 3'h7) st_r <= RX_STOP;
                end
                RX_STOP: if (full_w) begin
                    valid_o <= rx_i;
                    st_r <= RX_IDLE;
                end
                default: st_r <= RX_IDLE;
            endcase
        end
    end
endmodule

// file: core/rcp_host.sv
// Purpose: host end, turns apb writes into select pin levels and text bytes
// Assumes: software builds command lines byte by byte
// Notes: one byte in flight; a write to the tx register while busy is dropped
`timescale 1ns/1ps
module rcp_host #(
    parameter int BIT_CYC = rcp_pkg::BIT_CYC,
    parameter int GAP_CYC = rcp_pkg::GAP_CYC
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // link
    rcp_link_if.host link
);
    localparam int CW = $clog2(GAP_CYC + 1);
    typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_GAP} rcp_tx_type;
    rcp_tx_type st_r;
    logic [1:0] ctrl_r;
    logic [3:0] sel_r;
    logic [10:0] sh_r;
    logic [3:0] nb_r;
    logic [CW-1:0] cnt_r;
    logic cr_r;
    logic [3:0] sel_n_r;

    // ****************************************
    // register decode
    // ****************************************
    wire setup_w = psel_i & ~penable_i;
    wire wr_w = psel_i & penable_i & pready_o & pwrite_i;
    wire hit_ctrl_w = (paddr_i == rcp_pkg::REG_CTRL);
    wire hit_sel_w = (paddr_i == rcp_pkg::REG_SEL);
    wire hit_tx_w = (paddr_i == rcp_pkg::REG_TX);
    wire hit_st_w = (paddr_i == rcp_pkg::REG_STAT);
    wire mapped_w = hit_ctrl_w | hit_sel_w | hit_tx_w | hit_st_w;
    wire busy_w = (st_r != TX_IDLE);
    wire gap_w = (st_r == TX_GAP);
    wire [31:0] rdata_w = hit_ctrl_w ? {30'h0, ctrl_r} :
                          hit_sel_w ? {28'h0, sel_r} :
                          hit_st_w ? {30'h0, gap_w, busy_w} : 32'h0;
    wire pgm_w = ctrl_r[rcp_pkg::CTRL_PGM];
    wire tx_go_w = wr_w & hit_tx_w & ~busy_w & pgm_w;
    wire [3:0] nbits_w = ctrl_r[rcp_pkg::CTRL_STOP2] ? rcp_pkg::FRM_BITS2 : rcp_pkg::FRM_BITS1;
    wire bit_end_w = (cnt_r == CW'(BIT_CYC - 1));
    wire gap_end_w = (cnt_r == CW'(GAP_CYC - 1));

    assign link.sel_n = sel_n_r;

    // ****************************************
    // apb slave, zero wait states
    // ****************************************
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_o <= '0;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            ctrl_r <= '0;
            sel_r <= '0;
        end else begin
            pready_o <= setup_w;
            pslverr_o <= setup_w & ~mapped_w;
            if (setup_w) prdata_o <= rdata_w;
            if (wr_w & hit_ctrl_w) ctrl_r <= pwdata_i[1:0];
            if (wr_w & hit_sel_w) sel_r <= pwdata_i[3:0];
        end
    end

    // ****************************************
    // text transmitter and pins
    // ****************************************
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= TX_IDLE;
            sh_r <= '1;
            nb_r <= '0;
            cnt_r <= '0;
            cr_r <= 1'b0;
            sel_n_r <= '1;
        end else begin
            // select bits inverted, pin 0 idles high while programming
            sel_n_r <= {~sel_r[3:1], pgm_w ? sh_r[0] : ~sel_r[0]};
            cnt_r <= cnt_r + CW'(1);
            case (st_r)
                TX_IDLE: begin
                    cnt_r <= '0;
                    if (tx_go_w) begin
                        // start low, 8 data lsb first, one or two stop bits
                        sh_r <= {2'b11, pwdata_i[7:0], 1'b0};
                        nb_r <= nbits_w;
                        cr_r <= (pwdata_i[7:0] == rcp_pkg::CH_CR);
                        st_r <= TX_SEND;
                    end
                end
                TX_SEND: if (bit_end_w) begin
                    cnt_r <= '0;
                    sh_r <= {1'b1, sh_r[10:1]};
                    nb_r <= nb_r - 4'h1;
                    // after a line end hold off for the eeprom write time
                    if (nb_r == 4'h1) st_r <= cr_r ? TX_GAP : TX_IDLE;
                end
                TX_GAP: if (gap_end_w) st_r <= TX_IDLE;
                default: st_r <= TX_IDLE;
            endcase
        end
    end
endmodule

// file: core/rcp_dev.sv
// Purpose: receiver end, parses command text and drives synthesizer dividers
// Assumes: rst_i stands for power loss; eeprom store is not reset
// Notes: lines are parsed on the fly, nothing but a hash (which drops command mode) or a clear at line start acts before the line end
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module rcp_dev #(
    parameter int BIT_CYC = rcp_pkg::BIT_CYC,
    parameter int STABLE_CYC = rcp_pkg::STABLE_CYC
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // link
    rcp_link_if.dev link,
    // raw slicer level
    input wire logic slicer_i,
    // synthesizer setting
    output logic [16:0] n_div_o,
    output logic [13:0] r_div_o,
    output logic [4:0] chan_o,
    output rcp_pkg::rcp_mode_type mode_o,
    output logic tune_ok_o,
    // status
    output logic cmd_mode_o,
    output logic eep_wr_o,
    output logic data_o,
    output logic data_stable_o
);
    localparam int SW = $clog2(STABLE_CYC + 1);
    typedef enum logic {ST_RESTORE, ST_RUN} rcp_st_type;

    function automatic logic [16:0] dec_acc(input logic [16:0] a, input logic [3:0] d);
        logic [20:0] t;
        t = 21'(a) * 21'd10 + 21'(d);
        // saturate one above the limit so the value stays invalid
        if (t > 21'(rcp_pkg::N_MAX)) dec_acc = 17'(rcp_pkg::N_MAX + 1);
        else dec_acc = t[16:0];
    endfunction

    function automatic logic [2:0] sat_inc(input logic [2:0] n);
        sat_inc = (n == 3'h7) ? n : n + 3'h1;
    endfunction

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [3:0] sel_s1_r;
    logic [3:0] sel_s2_r;
    logic slc_s1_r;
    logic slc_s2_r;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sel_s1_r <= '1;
            sel_s2_r <= '1;
            slc_s1_r <= 1'b0;
            slc_s2_r <= 1'b0;
        end else begin
            sel_s1_r <= link.sel_n;
            sel_s2_r <= sel_s1_r;
            slc_s1_r <= slicer_i;
            slc_s2_r <= slc_s1_r;
        end
    end

    wire [7:0] rx_byte;
    wire rx_vld;
    rcp_uart_rx #(.BIT_CYC(BIT_CYC)) u_rx (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .rx_i(sel_s2_r[0]),
        .data_o(rx_byte),
        .valid_o(rx_vld)
    );

    // ****************************************
    // line tokenizer
    // ****************************************
    rcp_st_type st_r;
    logic [127:0] word_r;
    logic [127:0] word_nxt;
    logic [1:0] tok_r;
    logic [1:0] tok_nxt;
    logic [16:0] a0_r;
    logic [16:0] a0_nxt;
    logic [16:0] a1_r;
    logic [16:0] a1_nxt;
    logic [2:0] nd0_r;
    logic [2:0] nd0_nxt;
    logic [2:0] nd1_r;
    logic [2:0] nd1_nxt;
    logic bad_r;
    logic bad_nxt;
    logic unl_nxt;

    wire is_cr = (rx_byte == rcp_pkg::CH_CR);
    wire is_sp = (rx_byte == rcp_pkg::CH_SP);
    wire is_hash = (rx_byte == rcp_pkg::CH_HASH);
    wire is_dig = (rx_byte >= rcp_pkg::CH_0) && (rx_byte <= rcp_pkg::CH_9);
    wire [7:0] dig_w = rx_byte - rcp_pkg::CH_0;
    wire is_clr = (rx_byte == rcp_pkg::CH_CLR) && (tok_r == 2'h0) && (word_r == '0);
    wire line_end = rx_vld & is_cr;
    wire run_w = (st_r == ST_RUN);
    wire go_w = line_end & cmd_mode_o & ~bad_r & run_w;
    wire ch_ok = (nd0_r == 3'(rcp_pkg::CHAN_DIGITS)) && (a0_r <= 17'(rcp_pkg::CHAN_MAX));
    wire a0_ok = (nd0_r != 3'h0) && (a0_r <= 17'(rcp_pkg::N_MAX));
    wire a1_ok = (nd1_r != 3'h0) && (a1_r <= 17'(rcp_pkg::N_MAX));

    // ****************************************
    // command decode
    // ****************************************
    wire c_unlock = line_end & ~bad_r & (word_r == rcp_pkg::W_UNLOCK) & (tok_r == 2'h0);
    wire c_go = go_w & (word_r == rcp_pkg::W_GOCHAN) & (tok_r == 2'h1) & ch_ok;
    wire c_load = go_w & (word_r == rcp_pkg::W_LOAD) & (tok_r == 2'h2) & ch_ok & a1_ok;
    wire c_par = go_w & (word_r == rcp_pkg::W_PAR) & (tok_r == 2'h0);
    wire c_ser = go_w & (word_r == rcp_pkg::W_SER) & (tok_r == 2'h0);
    wire c_rdiv = go_w & (word_r == rcp_pkg::W_RDIV) & (tok_r == 2'h1) & a0_ok
                  & ~a0_r[rcp_pkg::R_RSV_BIT];
    wire c_single = go_w & (word_r == rcp_pkg::W_SINGLE) & (tok_r == 2'h1) & a0_ok;

    always_comb begin
        word_nxt = word_r;
        tok_nxt = tok_r;
        a0_nxt = a0_r;
        a1_nxt = a1_r;
        nd0_nxt = nd0_r;
        nd1_nxt = nd1_r;
        bad_nxt = bad_r;
        unl_nxt = cmd_mode_o;
        if (rx_vld) begin
            if (is_cr | is_hash | is_clr) begin
                // every line end, hash or clear starts a fresh line
                word_nxt = '0;
                tok_nxt = '0;
                a0_nxt = '0;
                a1_nxt = '0;
                nd0_nxt = '0;
                nd1_nxt = '0;
                bad_nxt = 1'b0;
                if (is_hash) unl_nxt = 1'b0;
                else if (c_unlock) unl_nxt = 1'b1;
            end else if (is_sp) begin
                if (tok_r != 2'h3) tok_nxt = tok_r + 2'h1;
            end else if (tok_r == 2'h0) begin
                word_nxt = {word_r[119:0], rx_byte};
            end else if (is_dig && tok_r == 2'h1) begin
                a0_nxt = dec_acc(a0_r, dig_w[3:0]);
                nd0_nxt = sat_inc(nd0_r);
            end else if (is_dig && tok_r == 2'h2) begin
                a1_nxt = dec_acc(a1_r, dig_w[3:0]);
                nd1_nxt = sat_inc(nd1_r);
            end else begin
                bad_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            word_r <= '0;
            tok_r <= '0;
            a0_r <= '0;
            a1_r <= '0;
            nd0_r <= '0;
            nd1_r <= '0;
            bad_r <= 1'b0;
            cmd_mode_o <= 1'b0;
        end else begin
            word_r <= word_nxt;
            tok_r <= tok_nxt;
            a0_r <= a0_nxt;
            a1_r <= a1_nxt;
            nd0_r <= nd0_nxt;
            nd1_r <= nd1_nxt;
            bad_r <= bad_nxt;
            cmd_mode_o <= unl_nxt;
        end
    end

    // ****************************************
    // non volatile store, survives rst_i
    // ****************************************
    logic [15:0] ee_tab [rcp_pkg::NCHAN];
    logic [15:0] ee_r_r;
    logic [4:0] ee_chan_r;
    rcp_pkg::rcp_mode_type ee_mode_r;
    initial begin
        for (int i = 0; i < rcp_pkg::NCHAN; i++) ee_tab[i] = rcp_pkg::DEF_N;
        ee_r_r = rcp_pkg::DEF_R;
        ee_chan_r = '0;
        ee_mode_r = rcp_pkg::RCP_PAR;
    end
    always @(posedge core_clk_i) begin
        if (c_load) ee_tab[a0_r[4:0]] <= a1_r[15:0];
        if (c_rdiv) ee_r_r <= a0_r[15:0];
        if (c_go) ee_chan_r <= a0_r[4:0];
        if (c_go | c_ser) ee_mode_r <= rcp_pkg::RCP_SER;
        if (c_par) ee_mode_r <= rcp_pkg::RCP_PAR;
        // mode is kept, the single divider is not
        if (c_single) ee_mode_r <= rcp_pkg::RCP_SINGLE;
    end

    // ****************************************
    // live tuning state
    // ****************************************
    logic [4:0] chan_r;
    logic [15:0] r_r;
    logic [15:0] nsing_r;
    logic sing_ok_r;
    rcp_pkg::rcp_mode_type mode_r;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= ST_RESTORE;
            chan_r <= '0;
            r_r <= '0;
            nsing_r <= '0;
            sing_ok_r <= 1'b0;
            mode_r <= rcp_pkg::RCP_PAR;
            eep_wr_o <= 1'b0;
        end else begin
            eep_wr_o <= c_load | c_rdiv | c_go | c_ser | c_par | c_single;
            if (st_r == ST_RESTORE) begin
                chan_r <= ee_chan_r;
                r_r <= ee_r_r;
                mode_r <= ee_mode_r;
                st_r <= ST_RUN;
            end
            if (c_go) chan_r <= a0_r[4:0];
            if (c_go | c_ser) mode_r <= rcp_pkg::RCP_SER;
            if (c_par) mode_r <= rcp_pkg::RCP_PAR;
            if (c_rdiv) r_r <= a0_r[15:0];
            if (c_single) begin
                nsing_r <= a0_r[15:0];
                mode_r <= rcp_pkg::RCP_SINGLE;
                sing_ok_r <= 1'b1;
            end
        end
    end

    // ****************************************
    // divider selection and outputs
    // ****************************************
    wire [4:0] par_ch = {1'b0, ~sel_s2_r};
    wire [4:0] use_ch = (mode_r == rcp_pkg::RCP_PAR) ? par_ch : chan_r;
    wire [15:0] n_base = (mode_r == rcp_pkg::RCP_SINGLE) ? nsing_r : ee_tab[use_ch];
    wire [16:0] n_eff = {1'b0, n_base} + (r_r[rcp_pkg::R_OFS_BIT] ? rcp_pkg::N_OFS : 17'h0);
    wire tune_w = run_w & ((mode_r != rcp_pkg::RCP_SINGLE) | sing_ok_r);
    logic [SW-1:0] stab_cnt_r;
    wire stab_w = (stab_cnt_r == SW'(STABLE_CYC - 1));

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            n_div_o <= '0;
            r_div_o <= '0;
            chan_o <= '0;
            mode_o <= rcp_pkg::RCP_PAR;
            tune_ok_o <= 1'b0;
            stab_cnt_r <= '0;
            data_stable_o <= 1'b0;
            data_o <= 1'b0;
        end else begin
            n_div_o <= n_eff;
            r_div_o <= r_r[rcp_pkg::R_W-1:0];
            chan_o <= use_ch;
            mode_o <= mode_r;
            tune_ok_o <= tune_w;
            // data held low until the slicer has settled
            if (!data_stable_o) stab_cnt_r <= stab_cnt_r + SW'(1);
            if (stab_w) data_stable_o <= 1'b1;
            data_o <= data_stable_o & slc_s2_r;
        end
    end
endmodule

// file: tb/rcp_props.sv
// Purpose: checks on the select pins and the receiver outputs
// Assumes: short sim counts handed in by the bench
// Notes: instantiated beside the link, no bind
`timescale 1ns/1ps
module rcp_props #(
    parameter int STABLE_CYC = 20
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // watched signals
    input wire logic [3:0] sel_n,
    input wire logic [4:0] chan_o,
    input wire rcp_pkg::rcp_mode_type mode_o,
    input wire logic tune_ok_o,
    input wire logic cmd_mode_o,
    input wire logic eep_wr_o,
    input wire logic data_o,
    input wire logic data_stable_o
);
    // saturating, so it never wraps back into the early window
    int unsigned cnt_r;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) cnt_r <= 0;
        else if (cnt_r < STABLE_CYC + 4) cnt_r <= cnt_r + 1;
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    AST_RST_IDLE: assert property ($fell(rst_i) |-> sel_n == 4'hf && !cmd_mode_o)
        else $error("pins or command mode not idle after reset");
    AST_START_BIT: assert property ($fell(sel_n[0]) |-> !sel_n[0] [*8])
        else $error("start bit too short");
    AST_EEP_PULSE: assert property (eep_wr_o |=> !eep_wr_o)
        else $error("store pulse longer than one cycle");
    AST_LOCKED: assert property (eep_wr_o |-> $past(cmd_mode_o, 2))
        else $error("command acted while locked");
    AST_PAR_CHAN: assert property ((mode_o == rcp_pkg::RCP_PAR && tune_ok_o && $stable(sel_n)) [*4]
        |-> chan_o == {1'b0, ~sel_n})
        else $error("parallel channel does not follow pins");
    AST_STABLE_EARLY: assert property (cnt_r < STABLE_CYC - 2 |-> !data_stable_o)
        else $error("data stable too early");
    AST_STABLE_LATE: assert property (cnt_r > STABLE_CYC + 2 |-> data_stable_o)
        else $error("data stable too late");
    AST_DATA_GATED: assert property (!data_stable_o |-> !data_o)
        else $error("data out before stable");
    cover property (eep_wr_o);
    cover property (mode_o == rcp_pkg::RCP_SINGLE);
    cover property ($fell(cmd_mode_o));
endmodule

// file: tb/testbench.sv
// Purpose: host and receiver joined by the link, driven over apb
// Assumes: bit time 16, gap 40, stable 20 cycles
// Notes: notes queued before each line that stores, popped on store pulses
`timescale 1ns/1ps
module testbench;
    logic core_clk_i = 0;
    logic rst_i = 1;
    logic psel_i = 0;
    logic penable_i = 0;
    logic pwrite_i = 0;
    logic slicer_i = 0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o, rd, v;
    logic pready_o, pslverr_o, err, tune_ok_o, cmd_mode_o, eep_wr_o, data_o, data_stable_o;
    logic [16:0] n_div_o;
    logic [13:0] r_div_o;
    logic [4:0] chan_o;
    rcp_pkg::rcp_mode_type mode_o;
    int failures = 0;
    int checked = 0;
    int cyc = 0;
    int seed = 19943;
    logic [15:0] tbl [32];
    logic [15:0] rv = rcp_pkg::DEF_R;
    logic [4:0] ch = 5'h00;
    logic [1:0] md = 2'h0;
    logic [37:0] q [$];
    logic [37:0] e;
    rcp_link_if link_inst ();
    rcp_host #(.BIT_CYC(16), .GAP_CYC(40)) rcp_host_inst (.core_clk_i(core_clk_i),
        .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .link(link_inst.host));
    rcp_dev #(.BIT_CYC(16), .STABLE_CYC(20)) rcp_dev_inst (.core_clk_i(core_clk_i),
        .rst_i(rst_i), .link(link_inst.dev), .slicer_i(slicer_i), .n_div_o(n_div_o),
        .r_div_o(r_div_o), .chan_o(chan_o), .mode_o(mode_o), .tune_ok_o(tune_ok_o),
        .cmd_mode_o(cmd_mode_o), .eep_wr_o(eep_wr_o), .data_o(data_o),
        .data_stable_o(data_stable_o));
    rcp_props #(.STABLE_CYC(20)) rcp_props_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .sel_n(link_inst.sel_n), .chan_o(chan_o), .mode_o(mode_o), .tune_ok_o(tune_ok_o),
        .cmd_mode_o(cmd_mode_o), .eep_wr_o(eep_wr_o), .data_o(data_o),
        .data_stable_o(data_stable_o));
    initial begin
        forever #2 core_clk_i = ~core_clk_i;
    end
    task conclude;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task cmp(input logic [16:0] g, input logic [16:0] x);
        checked++;
        if (g !== x) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        do @(posedge core_clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    // a tx write while busy is dropped, so poll before each byte
    task put(input logic [7:0] c);
        do apb(1'b0, rcp_pkg::REG_STAT, 32'h0); while (rd[1:0] !== 2'b00);
        apb(1'b1, rcp_pkg::REG_TX, {24'h0, c});
    endtask
    // command word from the package, zero bytes above it skipped, then the arguments
    task line(input logic [127:0] w, input string s);
        for (int i = 15; i >= 0; i--) if (w[i*8 +: 8] != 8'h00) put(w[i*8 +: 8]);
        for (int i = 0; i < s.len(); i++) put(s[i]);
        put(rcp_pkg::CH_CR);
        do apb(1'b0, rcp_pkg::REG_STAT, 32'h0); while (rd[1:0] !== 2'b00);
        #1;
    endtask
    task pwr_cycle;
        @(posedge core_clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        rst_i <= 1'b0;
        repeat (8) @(posedge core_clk_i);
        #1;
    endtask
    function automatic logic [16:0] nv(input logic [4:0] c);
        return {1'b0, tbl[c]} + (rv[15] ? rcp_pkg::N_OFS : 17'h0);
    endfunction
    task note(input logic [16:0] n);
        q.push_back({n, rv[13:0], ch, md});
    endtask
    always @(posedge core_clk_i) begin
        slicer_i <= 1'($random(seed));
        cyc++;
        if (cyc == 90000) begin
            failures++;
            conclude();
        end
    end
    initial begin
        forever begin
            @(posedge core_clk_i);
            if (eep_wr_o === 1'b1) begin
                repeat (2) @(posedge core_clk_i);
                #1;
                if (q.size() == 0) cmp(17'h1, 17'h0);
                else begin
                    e = q.pop_front();
                    cmp(n_div_o, e[37:21]);
                    cmp({3'h0, r_div_o}, {3'h0, e[20:7]});
                    cmp({12'h0, chan_o}, {12'h0, e[6:2]});
                    cmp({15'h0, mode_o}, {15'h0, e[1:0]});
                end
            end
        end
    end
    initial begin
        foreach (tbl[i]) tbl[i] = rcp_pkg::DEF_N;
        repeat (4) @(posedge core_clk_i);
        rst_i <= 1'b0;
        apb(1'b0, 8'h10, 32'h0);
        cmp({16'h0, err}, 17'h1);
        apb(1'b1, rcp_pkg::REG_CTRL, 32'h1);
        apb(1'b0, rcp_pkg::REG_CTRL, 32'h0);
        cmp(rd[16:0], 17'h1);
        line(rcp_pkg::W_GOCHAN, " 05");
        cmp({12'h0, chan_o}, 17'h0);
        line(rcp_pkg::W_UNLOCK, "");
        cmp({16'h0, cmd_mode_o}, 17'h1);
        tbl[31] = 16'hffff;
        note(nv(0));
        line(rcp_pkg::W_LOAD, " 31 65535");
        rv = 16'h8009;
        note(nv(0));
        line(rcp_pkg::W_RDIV, " 32777");
        ch = 5'd31;
        md = 2'd1;
        note(nv(31));
        line(rcp_pkg::W_GOCHAN, " 31");
        line(rcp_pkg::W_GOCHAN, " 32");
        line(rcp_pkg::W_LOAD, " 05 65536");
        line(rcp_pkg::W_RDIV, " 16384");
        md = 2'd2;
        note(17'h10064);
        line(rcp_pkg::W_SINGLE, " 00100");
        ch = 5'd0;
        md = 2'd0;
        note(nv(0));
        line(rcp_pkg::W_PAR, "");
        apb(1'b1, rcp_pkg::REG_CTRL, 32'h0);
        repeat (6) begin
            v = $random(seed);
            apb(1'b1, rcp_pkg::REG_SEL, {28'h0, v[3:0]});
            ch = {1'b0, v[3:0]};
            repeat (6) @(posedge core_clk_i);
            #1;
            cmp({12'h0, chan_o}, {12'h0, ch});
            cmp(n_div_o, nv(ch));
        end
        // pin 0 framed junk, maybe a hash: let the receiver idle, flush, unlock again
        apb(1'b1, rcp_pkg::REG_SEL, 32'h0);
        repeat (200) @(posedge core_clk_i);
        apb(1'b1, rcp_pkg::REG_CTRL, 32'h3);
        line(128'h0, "");
        line(rcp_pkg::W_UNLOCK, "");
        ch = 5'd31;
        md = 2'd1;
        note(nv(31));
        line(rcp_pkg::W_SER, "");
        line(128'h0, "#");
        cmp({16'h0, cmd_mode_o}, 17'h0);
        line(rcp_pkg::W_PAR, "");
        cmp({15'h0, mode_o}, 17'h1);
        pwr_cycle();
        cmp({12'h0, chan_o}, 17'h1f);
        cmp(n_div_o, nv(31));
        cmp({16'h0, cmd_mode_o}, 17'h0);
        cmp({16'h0, tune_ok_o}, 17'h1);
        // single mode across power loss stays dead until a mode command
        apb(1'b1, rcp_pkg::REG_CTRL, 32'h1);
        line(rcp_pkg::W_UNLOCK, "");
        md = 2'd2;
        note(17'h10064);
        line(rcp_pkg::W_SINGLE, " 00100");
        pwr_cycle();
        cmp({16'h0, tune_ok_o}, 17'h0);
        cmp({15'h0, mode_o}, 17'h2);
        apb(1'b1, rcp_pkg::REG_CTRL, 32'h1);
        line(rcp_pkg::W_UNLOCK, "");
        md = 2'd1;
        note(nv(31));
        line(rcp_pkg::W_SER, "");
        cmp({16'h0, tune_ok_o}, 17'h1);
        cmp(17'(q.size()), 17'h0);
        conclude();
    end
endmodule
